// >>> dcf_cfg.svh
// Constants for the dual clock fifo controller
`ifndef DCF_CFG_SVH
`define DCF_CFG_SVH
`define DCF_DW        9
`define DCF_OW        8
`define DCF_AW        6
`define DCF_CW        7
`define DCF_DEPTH     7'h40
`define DCF_NOFF      4
`define DCF_SYNC_W    17
`define DCF_OFF_EMPTY_LO 2'h0
`define DCF_OFF_EMPTY_HI 2'h1
`define DCF_OFF_FULL_LO  2'h2
`define DCF_OFF_FULL_HI  2'h3
`define DCF_OFF_LO_RST   8'h07
`define DCF_OFF_HI_RST   8'h00
`define DCF_DATA_RST     9'h000
`define DCF_PTR_RST      7'h00
`define DCF_SYNC_WCLK    16
`define DCF_SYNC_RCLK    15
`define DCF_PTR_STEP     7'h01
`define DCF_SEL_STEP     2'h1
`endif

// >>> dcf_pkg.sv
// Types for the dual clock fifo controller
package dcf_pkg;
    typedef enum logic [1:0] {
        DCF_SEL_EMPTY_LO = 2'b00,
        DCF_SEL_EMPTY_HI = 2'b01,
        DCF_SEL_FULL_LO  = 2'b10,
        DCF_SEL_FULL_HI  = 2'b11
    } dcf_sel_t;
    typedef logic [7:0] dcf_off_t;
endpackage

// >>> dcf_fifo_ctrl.sv
// Dual clock fifo controller with programmable flags
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_fifo_ctrl
    import dcf_pkg::*;
(
    // Core clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // Pin reset and mode pin
    input  wire logic                 reset_n,
    input  wire logic                 second_enable_or_load,
    // Write port pins
    input  wire logic                 write_clk,
    input  wire logic                 primary_write_enable_n,
    input  wire logic [`DCF_DW-1:0]   write_data_bus,
    // Read port pins
    input  wire logic                 read_clk,
    input  wire logic                 read_enable_a_n,
    input  wire logic                 read_enable_b_n,
    input  wire logic                 output_enable_n,
    output logic      [`DCF_DW-1:0]   read_data_bus,
    output logic                      read_data_oe,
    // Status flags
    output logic                      full_flag_n,
    output logic                      almost_full_flag_n,
    output logic                      empty_flag_n,
    output logic                      almost_empty_flag_n
);

    // Threshold from an offset byte pair, trimmed to address width
    function automatic logic [`DCF_CW-1:0] thr(input dcf_off_t lo,
                                                input dcf_off_t hi);
        logic [15:0] w;
        w = {hi, lo};
        thr = {1'b0, w[`DCF_AW-1:0]};
    endfunction

    // Pin synchronisers
    logic [`DCF_SYNC_W-1:0] s1_q;
    logic [`DCF_SYNC_W-1:0] s2_q;
    logic                   wclk_p_q;
    logic                   rclk_p_q;

    always_ff @(posedge core_clk)
    begin
        s1_q <= {write_clk, read_clk, reset_n, primary_write_enable_n,
                 second_enable_or_load, read_enable_a_n, read_enable_b_n,
                 output_enable_n, write_data_bus};
        s2_q <= s1_q;
        wclk_p_q <= s2_q[`DCF_SYNC_WCLK];
        rclk_p_q <= s2_q[`DCF_SYNC_RCLK];
    end

    logic              wclk_s;
    logic              rclk_s;
    logic              rstn_s;
    logic              wen_s;
    logic              load_s;
    logic              rena_s;
    logic              renb_s;
    logic              oen_s;
    logic [`DCF_DW-1:0] wdata_s;
    logic              wedge;
    logic              redge;
    logic              rst_all;

    assign {wclk_s, rclk_s, rstn_s, wen_s, load_s, rena_s, renb_s, oen_s,
            wdata_s} = s2_q;
    // Write and read sides advance only on their own pin clock edges
    assign wedge   = wclk_s & ~wclk_p_q;
    assign redge   = rclk_s & ~rclk_p_q;
    assign rst_all = rst | ~rstn_s;

    // State
    logic [`DCF_CW-1:0] wp_q, wp_d;
    logic [`DCF_CW-1:0] rp_q, rp_d;
    logic [`DCF_DW-1:0] rdata_q, rdata_d;
    logic               oe_q, oe_d;
    logic               dual_q, dual_d;
    dcf_sel_t           sel_q, sel_d;
    dcf_off_t           off_q [`DCF_NOFF];
    dcf_off_t           off_d [`DCF_NOFF];
    logic               ff_q, ff_d;
    logic               af_q, af_d;
    logic               ef_q, ef_d;
    logic               ae_q, ae_d;
    logic [`DCF_DW-1:0] mem_q [`DCF_DEPTH];

    logic [`DCF_CW-1:0] cnt;
    logic [`DCF_CW-1:0] cnt_n;
    logic               wr_fifo;
    logic               wr_ok;
    logic               wr_off;
    logic               rd_off;
    logic               rd_ok;

    always_comb
    begin
        wp_d    = wp_q;
        rp_d    = rp_q;
        rdata_d = rdata_q;
        sel_d   = sel_q;
        off_d   = off_q;
        ff_d    = ff_q;
        af_d    = af_q;
        ef_d    = ef_q;
        ae_d    = ae_q;
        oe_d    = ~oen_s;
        dual_d  = dual_q;
        cnt     = wp_q - rp_q;
        // Both modes write the array with load high and enable low
        wr_fifo = wedge & ~wen_s & load_s;
        wr_ok   = wr_fifo & (cnt != `DCF_DEPTH);
        wr_off  = wedge & ~dual_q & ~load_s & ~wen_s;
        rd_off  = redge & ~dual_q & ~load_s & ~rena_s & ~renb_s;
        rd_ok   = redge & ~rena_s & ~renb_s & ~rd_off
                  & (wp_q != rp_q);
        if (wr_ok)
        begin
            wp_d = wp_q + `DCF_PTR_STEP;
        end
        if (rd_ok)
        begin
            rp_d    = rp_q + `DCF_PTR_STEP;
            rdata_d = mem_q[rp_q[`DCF_AW-1:0]];
        end
        if (wr_off)
        begin
            off_d[sel_q] = wdata_s[`DCF_OW-1:0];
            sel_d        = dcf_sel_t'(sel_q + `DCF_SEL_STEP);
        end
        else if (rd_off)
        begin
            rdata_d = {1'b0, off_q[sel_q]};
            sel_d   = dcf_sel_t'(sel_q + `DCF_SEL_STEP);
        end
        cnt_n = wp_d - rp_d;
        if (wedge)
        begin
            // Full side sees reads only at its own edge
            ff_d = (cnt_n != `DCF_DEPTH);
            af_d = cnt_n < (`DCF_DEPTH - thr(off_q[`DCF_OFF_FULL_LO],
                                              off_q[`DCF_OFF_FULL_HI]));
        end
        if (redge)
        begin
            ef_d = (wp_d != rp_d);
            ae_d = cnt_n > thr(off_q[`DCF_OFF_EMPTY_LO],
                               off_q[`DCF_OFF_EMPTY_HI]);
        end
        if (rst_all)
        begin
            wp_d    = `DCF_PTR_RST;
            rp_d    = `DCF_PTR_RST;
            rdata_d = `DCF_DATA_RST;
            sel_d   = DCF_SEL_EMPTY_LO;
            off_d[`DCF_OFF_EMPTY_LO] = `DCF_OFF_LO_RST;
            off_d[`DCF_OFF_EMPTY_HI] = `DCF_OFF_HI_RST;
            off_d[`DCF_OFF_FULL_LO]  = `DCF_OFF_LO_RST;
            off_d[`DCF_OFF_FULL_HI]  = `DCF_OFF_HI_RST;
            ff_d    = 1'b1;
            af_d    = 1'b1;
            ef_d    = 1'b0;
            ae_d    = 1'b0;
            // Mode is caught while the pin reset is low
            dual_d  = rst ? 1'b0 : load_s;
        end
        if (rst)
        begin
            oe_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        wp_q    <= wp_d;
        rp_q    <= rp_d;
        rdata_q <= rdata_d;
        oe_q    <= oe_d;
        dual_q  <= dual_d;
        sel_q   <= sel_d;
        off_q   <= off_d;
        ff_q    <= ff_d;
        af_q    <= af_d;
        ef_q    <= ef_d;
        ae_q    <= ae_d;
    end

    // Storage array, written only by an accepted write
    logic [`DCF_DW-1:0] mem_d [`DCF_DEPTH];

    always_comb
    begin
        mem_d = mem_q;
        if (wr_ok)
        begin
            mem_d[wp_q[`DCF_AW-1:0]] = wdata_s;
        end
    end

    always_ff @(posedge core_clk)
    begin
        mem_q <= mem_d;
    end

    assign read_data_bus       = rdata_q;
    assign read_data_oe        = oe_q;
    assign full_flag_n         = ff_q;
    assign almost_full_flag_n  = af_q;
    assign empty_flag_n        = ef_q;
    assign almost_empty_flag_n = ae_q;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_reset_flags: assert property (
        rst_all |=> ff_q && af_q && !ef_q && !ae_q
        && rdata_q == `DCF_DATA_RST)
        else $error("flags or output wrong after reset");
    a_reset_ptrs: assert property (
        rst_all |=> wp_q == `DCF_PTR_RST && rp_q == `DCF_PTR_RST)
        else $error("pointers not cleared by reset");
    a_full_blocks: assert property (
        !rst_all && wedge && (wp_q - rp_q) == `DCF_DEPTH |=> $stable(wp_q))
        else $error("write accepted while full");
    a_empty_blocks: assert property (
        !rst_all && redge && !rd_off && wp_q == rp_q |=> $stable(rp_q))
        else $error("read accepted while empty");
    a_out_hold: assert property (
        !rst_all && redge && (rena_s || renb_s) |=> $stable(rdata_q))
        else $error("output changed with read disabled");
    a_flag_edge: assert property (
        !rst_all && !wedge |=> $stable(ff_q) && $stable(af_q))
        else $error("full side flag moved without write edge");
    a_empty_eq: assert property (
        !rst_all && redge |=> ef_q == (wp_q != rp_q))
        else $error("empty flag disagrees with pointers");
    a_off_seq: assert property (
        !rst_all && wr_off
        |=> sel_q == dcf_sel_t'($past(sel_q) + `DCF_SEL_STEP)
        && off_q[$past(sel_q)] == $past(wdata_s[`DCF_OW-1:0]))
        else $error("offset write sequence broken");
    a_off_noop: assert property (
        !rst_all && wedge && !load_s && wen_s && !redge
        |=> $stable(sel_q) && $stable(wp_q))
        else $error("no-op edge changed state");
    a_mode_hold: assert property (
        !rst_all ##1 !rst_all |-> $stable(dual_q))
        else $error("mode changed outside reset");

    // Word path
    a_wr_store: assert property (
        !rst_all && wr_ok |=> wp_q == $past(wp_q) + `DCF_PTR_STEP
        && mem_q[$past(wp_q[`DCF_AW-1:0])] == $past(wdata_s))
        else $error("accepted write not stored");

    a_rd_word: assert property (
        !rst_all && rd_ok |=> rp_q == $past(rp_q) + `DCF_PTR_STEP
        && rdata_q == $past(mem_q[rp_q[`DCF_AW-1:0]]))
        else $error("read did not deliver the stored word");

    a_dual_gate: assert property (
        !rst_all && dual_q && wedge && (wen_s || !load_s)
        |=> $stable(wp_q) && $stable(sel_q))
        else $error("dual enable write without both enables");

    a_oe_follow: assert property (
        1'b1 |=> read_data_oe == !$past(oen_s))
        else $error("output enable does not follow its pin");

    // Flag thresholds
    a_full_flag: assert property (
        !rst_all && wedge
        |=> full_flag_n == ((wp_q - rp_q) != `DCF_DEPTH))
        else $error("full flag disagrees with count");

    a_afull_thr: assert property (
        !rst_all && wedge |=> almost_full_flag_n == ((wp_q - rp_q)
        < (`DCF_DEPTH - thr($past(off_q[`DCF_OFF_FULL_LO]),
                            $past(off_q[`DCF_OFF_FULL_HI])))))
        else $error("almost full flag disagrees with offset");

    a_aempty_thr: assert property (
        !rst_all && redge |=> almost_empty_flag_n == ((wp_q - rp_q)
        > thr($past(off_q[`DCF_OFF_EMPTY_LO]),
              $past(off_q[`DCF_OFF_EMPTY_HI]))))
        else $error("almost empty flag disagrees with offset");

    // Offset registers
    a_reset_offs: assert property (
        rst_all |=> off_q[`DCF_OFF_EMPTY_LO] == `DCF_OFF_LO_RST
        && off_q[`DCF_OFF_EMPTY_HI] == `DCF_OFF_HI_RST
        && off_q[`DCF_OFF_FULL_LO] == `DCF_OFF_LO_RST
        && off_q[`DCF_OFF_FULL_HI] == `DCF_OFF_HI_RST
        && sel_q == DCF_SEL_EMPTY_LO)
        else $error("offsets not restored by reset");

    a_off_read: assert property (
        !rst_all && rd_off |=> rdata_q == {1'b0, $past(off_q[sel_q])}
        && sel_q == dcf_sel_t'($past(sel_q) + `DCF_SEL_STEP))
        else $error("offset read sequence broken");

    a_off_keep: assert property (
        !rst_all && load_s |=> $stable(sel_q))
        else $error("offset position moved in normal operation");

endmodule

// >>> dcf_host_model.sv
// Pin model of the writing and reading logic around the fifo
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_host_model
(
    // Write side
    output logic               write_clk,
    output logic               primary_write_enable_n,
    output logic               second_enable_or_load,
    output logic [`DCF_DW-1:0] write_data_bus,
    // Read side
    output logic               read_clk,
    output logic               read_enable_a_n,
    output logic               read_enable_b_n
);
    initial
    begin
        write_clk = 1'b0;
        read_clk = 1'b0;
        primary_write_enable_n = 1'b1;
        second_enable_or_load = 1'b0;
        write_data_bus = '0;
        read_enable_a_n = 1'b1;
        read_enable_b_n = 1'b1;
    end
    // Load level held steady through a reset
    task automatic hold_ld(input logic ld);
        second_enable_or_load = ld;
    endtask
    // One write clock period; never overlaps a read
    task automatic wr(input logic [`DCF_DW-1:0] d, input logic w,
                      input logic ld);
        primary_write_enable_n = w;
        second_enable_or_load = ld;
        write_data_bus = d;
        #40 write_clk = 1'b1;
        #40 write_clk = 1'b0;
        write_data_bus = ~d; // Released bus keeps no stale word
    endtask
    // One read clock period
    task automatic rd(input logic a, input logic b, input logic ld);
        read_enable_a_n = a;
        read_enable_b_n = b;
        second_enable_or_load = ld;
        #40 read_clk = 1'b1;
        #40 read_clk = 1'b0;
    endtask
endmodule

// >>> dcf_fifo_ctrl_tb.sv
// Self-checking bench for the dual clock fifo controller
`timescale 1ns/1ps
`include "dcf_cfg.svh"
module dcf_fifo_ctrl_tb
    import dcf_pkg::*;
;
    logic               core_clk, rst, reset_n, output_enable_n;
    logic               write_clk, read_clk, wen_n, ld, ren_a_n, ren_b_n;
    logic [`DCF_DW-1:0] wdata, rdata, last;
    logic               oe, ff, af, ef, ae, ff_e, af_e, ef_e, ae_e, dual;
    logic [`DCF_DW-1:0] q[$];
    dcf_off_t           off[4];
    int                 fails, num_checks, seq;

    dcf_host_model host (.write_clk, .primary_write_enable_n(wen_n),
        .second_enable_or_load(ld), .write_data_bus(wdata), .read_clk,
        .read_enable_a_n(ren_a_n), .read_enable_b_n(ren_b_n));
    dcf_fifo_ctrl dut (.core_clk, .rst, .reset_n, .second_enable_or_load(ld),
        .write_clk, .primary_write_enable_n(wen_n), .write_data_bus(wdata),
        .read_clk, .read_enable_a_n(ren_a_n), .read_enable_b_n(ren_b_n),
        .output_enable_n, .read_data_bus(rdata), .read_data_oe(oe),
        .full_flag_n(ff), .almost_full_flag_n(af), .empty_flag_n(ef),
        .almost_empty_flag_n(ae));

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [8:0] e,
                       input logic [8:0] g);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic flags();
        chk("full_flag_n", {8'h00, ff_e}, {8'h00, ff});
        chk("almost_full_flag_n", {8'h00, af_e}, {8'h00, af});
        chk("empty_flag_n", {8'h00, ef_e}, {8'h00, ef});
        chk("almost_empty_flag_n", {8'h00, ae_e},
            {8'h00, ae});
    endtask

    task automatic expect_reset(input logic md);
        q.delete();
        off = '{8'h07, 8'h00, 8'h07, 8'h00};
        seq = 0;
        dual = md;
        last = '0;
        {ff_e, af_e, ef_e, ae_e} = 4'b1100;
        chk("read_data_bus", last, rdata);
        flags();
    endtask

    task automatic wr_step(input logic [8:0] d, input logic w, input logic l);
        host.wr(d, w, l);
        if (!w && !l && !dual)
        begin
            off[seq] = d[7:0];
            seq = (seq + 1) % 4;
        end
        else if (!w && l && q.size() < 64)
            q.push_back(d);
        ff_e = q.size() != 64;
        af_e = q.size() < 64 - off[2][5:0];
        flags();
    endtask

    task automatic rd_step(input logic a, input logic b, input logic l);
        host.rd(a, b, l);
        if (!a && !b && !l && !dual)
        begin
            last = {1'b0, off[seq]};
            seq = (seq + 1) % 4;
        end
        else if (!a && !b && q.size() > 0)
            last = q.pop_front();
        ef_e = q.size() != 0;
        ae_e = q.size() > off[0][5:0];
        chk("read_data_bus", last, rdata);
        flags();
    endtask

    task automatic end_sim();
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #100000;
        fails++;
        end_sim();
    end

    initial
    begin
        rst = 1'b1;
        reset_n = 1'b1;
        output_enable_n = 1'b0;
        fails = 0;
        num_checks = 0;
        void'($urandom(98946));
        repeat (20) @(posedge core_clk);
        #1 rst = 1'b0;
        repeat (8) @(posedge core_clk);
        #1 expect_reset(1'b0);
        for (int i = 0; i < 4; i++)
            rd_step(1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 6; i++)
            if (i == 2)
                wr_step(9'($urandom), 1'b0, 1'b1);
            else if (i == 4)
                wr_step(9'($urandom), 1'b1, 1'b0);
            else
                wr_step(i % 3 ? 9'($urandom) : 9'($urandom_range(2, 12)),
                        1'b0, 1'b0);
        for (int i = 0; i < 4; i++)
            rd_step(1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 64; i++)
            wr_step(9'($urandom), 1'b0, 1'b1);
        rd_step(1'b1, 1'b0, 1'b1);
        rd_step(1'b0, 1'b0, 1'b1);
        wr_step(9'($urandom), 1'b1, 1'b1);
        for (int i = 0; i < 200 && q.size() > 0; i++)
            rd_step(1'b0, 1'($urandom_range(0, 3) == 0),
                    1'b1);
        rd_step(1'b0, 1'b0, 1'b1);
        output_enable_n = 1'b1;
        repeat (8) @(posedge core_clk);
        #1 chk("read_data_oe", 9'h000, {8'h00, oe});
        output_enable_n = 1'b0;
        repeat (8) @(posedge core_clk);
        #1 chk("read_data_oe", 9'h001, {8'h00, oe});
        host.hold_ld(1'b1);
        reset_n = 1'b0;
        repeat (24) @(posedge core_clk);
        #1 reset_n = 1'b1;
        repeat (8) @(posedge core_clk);
        #1 expect_reset(1'b1);
        wr_step(9'($urandom), 1'b0, 1'b1);
        wr_step(9'($urandom), 1'b0, 1'b0);
        wr_step(9'($urandom), 1'b1, 1'b1);
        for (int i = 0; i < 3; i++)
            rd_step(1'(i == 0), 1'b0, 1'b0);
        end_sim();
    end
endmodule
